// *** evx_defs.svh ***
`ifndef EVX_DEFS_SVH
`define EVX_DEFS_SVH
`define EVX_VEC_W        8
`define EVX_DIV_W        16
`define EVX_SRC_N        19
`define EVX_RESERVED_TOP 8'h1f
`define EVX_VEC_DE       8'h00
`define EVX_VEC_DB       8'h01
`define EVX_VEC_NMI      8'h02
`define EVX_VEC_BP       8'h03
`define EVX_VEC_OF       8'h04
`define EVX_VEC_BR       8'h05
`define EVX_VEC_UD       8'h06
`define EVX_VEC_NM       8'h07
`define EVX_VEC_DF       8'h08
`define EVX_VEC_TS       8'h0a
`define EVX_VEC_NP       8'h0b
`define EVX_VEC_SS       8'h0c
`define EVX_VEC_GP       8'h0d
`define EVX_VEC_PF       8'h0e
`define EVX_VEC_MF       8'h10
`define EVX_VEC_AC       8'h11
`define EVX_VEC_MC       8'h12
`define EVX_VEC_XF       8'h13
`define EVX_VEC_SX       8'h1e
`define EVX_ZERO16       16'h0000
`define EVX_ZERO8        8'h00
`define EVX_SMIN8        8'h80
`define EVX_SMAX8        8'h7f
`endif

// *** evx_div_check.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "evx_defs.svh"
// Combinational divide-error detector, 16 by 8 bit divide
module evx_div_check (
  evx_div_if.chk port_if
);
  logic [15:0] mag_n;
  logic [7:0]  mag_d;
  logic [15:0] uq;
  logic        neg;
  logic        zero_d;
  logic        ovf;
  // Quotient range check; zero divisor guarded before the divide
  always_comb begin
    zero_d = (port_if.divisor == `EVX_ZERO8);
    neg    = port_if.signed_op & (port_if.dividend[15] ^ port_if.divisor[7]);
    mag_n  = (port_if.signed_op && port_if.dividend[15]) ? 16'(-port_if.dividend)
                                                         : port_if.dividend;
    mag_d  = (port_if.signed_op && port_if.divisor[7]) ? 8'(-port_if.divisor)
                                                       : port_if.divisor;
    uq     = zero_d ? `EVX_ZERO16 : (mag_n / 16'(mag_d));
    if (!port_if.signed_op) begin
      ovf = (uq[15:8] != `EVX_ZERO8);
    end else if (neg) begin
      ovf = (uq > 16'({`EVX_ZERO8, `EVX_SMIN8}));
    end else begin
      ovf = (uq > 16'({`EVX_ZERO8, `EVX_SMAX8}));
    end
    port_if.err = port_if.req & (zero_d | ovf);
  end
endmodule // evx_div_check
`default_nettype wire

// *** evx_div_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// Divide check request and verdict
interface evx_div_if;
  logic        req;
  logic        signed_op;
  logic [15:0] dividend;
  logic [7:0]  divisor;
  logic        err;
  modport chk (input req, input signed_op, input dividend, input divisor, output err);
  modport use_end (output req, output signed_op, output dividend, output divisor, input err);
endinterface
`default_nettype wire

// *** evx_irq_source.sv ***
`timescale 1ns/1ps
`default_nettype none
module evx_irq_source (
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  input  wire logic       raise_in,
  input  wire logic [7:0] vector_in,
  input  wire logic       irq_ack_in,
  output logic            irq_out,
  output logic [7:0]      vector_out
);
  logic       pend_r;
  logic [7:0] vec_r;
  // Request stays up until taken; a masked core only delays it
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pend_r <= 1'b0;
      vec_r  <= 8'h5a;
    end else begin
      if (irq_ack_in) pend_r <= 1'b0;
      else if (raise_in) pend_r <= 1'b1;
      if (!pend_r) vec_r <= raise_in ? vector_in : ~vec_r;
    end
  end
  // Drop at the ack so the core never sees it twice; idle bus keeps moving
  assign irq_out = pend_r && !irq_ack_in;
  assign vector_out = irq_out ? vec_r : ~vec_r;
endmodule // evx_irq_source
`default_nettype wire

// *** evx_pkg.sv ***
package evx_pkg;
  // Kind of event
  typedef enum logic [1:0] {
    EVX_KIND_NONE  = 2'b00,
    EVX_KIND_FAULT = 2'b01,
    EVX_KIND_TRAP  = 2'b10,
    EVX_KIND_ABORT = 2'b11
  } evx_kind_t;
  // Class for double-fault escalation
  typedef enum logic [1:0] {
    EVX_CLS_NONE    = 2'b00,
    EVX_CLS_BENIGN  = 2'b01,
    EVX_CLS_CONTRIB = 2'b10,
    EVX_CLS_EITHER  = 2'b11
  } evx_cls_t;
  typedef enum logic [1:0] {
    EVX_ST_IDLE = 2'b00,
    EVX_ST_SHOW = 2'b01
  } evx_state_t;
  // Precision: none means unclassified
  typedef enum logic [1:0] {
    EVX_PREC_NONE = 2'b00,
    EVX_PREC_YES  = 2'b01,
    EVX_PREC_NO   = 2'b10
  } evx_prec_t;
endpackage

// *** evx_vector_map.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "evx_defs.svh"
module evx_vector_map (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic        div_req_in,
  input  wire logic        div_signed_in,
  input  wire logic [15:0] div_dividend_in,
  input  wire logic [7:0]  div_divisor_in,
  input  wire logic        debug_exc_in,
  input  wire logic        debug_is_trap_in,
  input  wire logic        nmi_in,
  input  wire logic        breakpoint_exc_in,
  input  wire logic        overflow_exc_in,
  input  wire logic        bound_range_exc_in,
  input  wire logic        invalid_opcode_exc_in,
  input  wire logic        device_unavailable_exc_in,
  input  wire logic        double_fault_exc_in,
  input  wire logic        invalid_task_segment_exc_in,
  input  wire logic        segment_absent_exc_in,
  input  wire logic        stack_exc_in,
  input  wire logic        general_protection_exc_in,
  input  wire logic        page_fault_exc_in,
  input  wire logic        float_pending_exc_in,
  input  wire logic        alignment_check_exc_in,
  input  wire logic        machine_check_exc_in,
  input  wire logic        simd_float_exc_in,
  input  wire logic        security_exc_in,
  input  wire logic        software_interrupt_instr_in,
  input  wire logic [7:0]  software_vector_in,
  input  wire logic        maskable_external_irq_in,
  input  wire logic [7:0]  external_vector_in,
  input  wire logic        interrupt_enable_flag_in,
  input  wire logic [63:0] cur_ip_in,
  input  wire logic [63:0] next_ip_in,
  output logic             event_valid_out,
  output logic [7:0]       event_vector_out,
  output logic [1:0]       event_kind_out,
  output logic [1:0]       event_prec_out,
  output logic [1:0]       event_class_out,
  output logic             event_err_code_out,
  output logic             event_discard_out,
  output logic [63:0]      saved_ip_out,
  output logic             irq_ack_out,
  output logic             irq_pending_out
);
  typedef struct packed {
    evx_pkg::evx_state_t st;
    logic                valid;
    logic [7:0]          vec;
    evx_pkg::evx_kind_t  kind;
    evx_pkg::evx_prec_t  prec;
    evx_pkg::evx_cls_t   cls;
    logic                err_code;
    logic                discard;
    logic [63:0]         ip;
    logic                ack;
    logic                pend;
  } evx_state_s_t;

  evx_state_s_t state_r;
  evx_state_s_t state_nxt;
  logic         div_err;
  logic         take_irq;

  // Divide check kept out of the priority path
  evx_div_if div_port();
  assign div_port.req       = div_req_in;
  assign div_port.signed_op = div_signed_in;
  assign div_port.dividend  = div_dividend_in;
  assign div_port.divisor   = div_divisor_in;
  assign div_err            = div_port.err;

  evx_div_check u_div (
    .port_if (div_port.chk)
  );

  // Maskable request held pending until the enable flag allows it
  assign take_irq = maskable_external_irq_in & interrupt_enable_flag_in;

  // Fixed priority: aborts first, then faults by vector, then traps, then interrupts
  always_comb begin
    state_nxt          = state_r;
    state_nxt.valid    = 1'b0;
    state_nxt.ack      = 1'b0;
    state_nxt.pend     = maskable_external_irq_in & ~interrupt_enable_flag_in;
    state_nxt.vec      = `EVX_VEC_DE;
    state_nxt.kind     = evx_pkg::EVX_KIND_NONE;
    state_nxt.prec     = evx_pkg::EVX_PREC_NONE;
    state_nxt.cls      = evx_pkg::EVX_CLS_NONE;
    state_nxt.err_code = 1'b0;
    state_nxt.discard  = 1'b0;
    state_nxt.ip       = cur_ip_in;
    state_nxt.st       = evx_pkg::EVX_ST_IDLE;
    // Only one branch wins, so one event per cycle
    if (double_fault_exc_in) begin
      state_nxt.vec      = `EVX_VEC_DF;
      state_nxt.kind     = evx_pkg::EVX_KIND_ABORT;
      state_nxt.prec     = evx_pkg::EVX_PREC_NO;
      state_nxt.err_code = 1'b1;
      state_nxt.valid    = 1'b1;
    end else if (machine_check_exc_in) begin
      state_nxt.vec   = `EVX_VEC_MC;
      state_nxt.kind  = evx_pkg::EVX_KIND_ABORT;
      state_nxt.prec  = evx_pkg::EVX_PREC_NO;
      state_nxt.valid = 1'b1;
    end else if (div_err) begin
      // Never gated by any enable input
      state_nxt.vec      = `EVX_VEC_DE;
      state_nxt.kind     = evx_pkg::EVX_KIND_FAULT;
      state_nxt.prec     = evx_pkg::EVX_PREC_YES;
      state_nxt.cls      = evx_pkg::EVX_CLS_CONTRIB;
      state_nxt.err_code = 1'b0;
      state_nxt.ip       = cur_ip_in;
      state_nxt.valid    = 1'b1;
    end else if (debug_exc_in) begin
      state_nxt.vec   = `EVX_VEC_DB;
      state_nxt.kind  = debug_is_trap_in ? evx_pkg::EVX_KIND_TRAP : evx_pkg::EVX_KIND_FAULT;
      state_nxt.prec  = evx_pkg::EVX_PREC_YES;
      state_nxt.cls   = evx_pkg::EVX_CLS_BENIGN;
      state_nxt.valid = 1'b1;
    end else if (bound_range_exc_in) begin
      state_nxt.vec   = `EVX_VEC_BR;
      state_nxt.kind  = evx_pkg::EVX_KIND_FAULT;
      state_nxt.prec  = evx_pkg::EVX_PREC_YES;
      state_nxt.cls   = evx_pkg::EVX_CLS_BENIGN;
      state_nxt.valid = 1'b1;
    end else if (invalid_opcode_exc_in) begin
      state_nxt.vec   = `EVX_VEC_UD;
      state_nxt.kind  = evx_pkg::EVX_KIND_FAULT;
      state_nxt.prec  = evx_pkg::EVX_PREC_YES;
      state_nxt.cls   = evx_pkg::EVX_CLS_BENIGN;
      state_nxt.valid = 1'b1;
    end else if (device_unavailable_exc_in) begin
      state_nxt.vec   = `EVX_VEC_NM;
      state_nxt.kind  = evx_pkg::EVX_KIND_FAULT;
      state_nxt.prec  = evx_pkg::EVX_PREC_YES;
      state_nxt.cls   = evx_pkg::EVX_CLS_BENIGN;
      state_nxt.valid = 1'b1;
    end else if (invalid_task_segment_exc_in) begin
      state_nxt.vec      = `EVX_VEC_TS;
      state_nxt.kind     = evx_pkg::EVX_KIND_FAULT;
      state_nxt.prec     = evx_pkg::EVX_PREC_YES;
      state_nxt.cls      = evx_pkg::EVX_CLS_CONTRIB;
      state_nxt.err_code = 1'b1;
      state_nxt.valid    = 1'b1;
    end else if (segment_absent_exc_in) begin
      state_nxt.vec      = `EVX_VEC_NP;
      state_nxt.kind     = evx_pkg::EVX_KIND_FAULT;
      state_nxt.prec     = evx_pkg::EVX_PREC_YES;
      state_nxt.cls      = evx_pkg::EVX_CLS_CONTRIB;
      state_nxt.err_code = 1'b1;
      state_nxt.valid    = 1'b1;
    end else if (stack_exc_in) begin
      state_nxt.vec      = `EVX_VEC_SS;
      state_nxt.kind     = evx_pkg::EVX_KIND_FAULT;
      state_nxt.prec     = evx_pkg::EVX_PREC_YES;
      state_nxt.cls      = evx_pkg::EVX_CLS_CONTRIB;
      state_nxt.err_code = 1'b1;
      state_nxt.valid    = 1'b1;
    end else if (general_protection_exc_in) begin
      state_nxt.vec      = `EVX_VEC_GP;
      state_nxt.kind     = evx_pkg::EVX_KIND_FAULT;
      state_nxt.prec     = evx_pkg::EVX_PREC_YES;
      state_nxt.cls      = evx_pkg::EVX_CLS_CONTRIB;
      state_nxt.err_code = 1'b1;
      state_nxt.valid    = 1'b1;
    end else if (page_fault_exc_in) begin
      state_nxt.vec      = `EVX_VEC_PF;
      state_nxt.kind     = evx_pkg::EVX_KIND_FAULT;
      state_nxt.prec     = evx_pkg::EVX_PREC_YES;
      state_nxt.cls      = evx_pkg::EVX_CLS_EITHER;
      state_nxt.err_code = 1'b1;
      state_nxt.valid    = 1'b1;
    end else if (float_pending_exc_in) begin
      state_nxt.vec   = `EVX_VEC_MF;
      state_nxt.kind  = evx_pkg::EVX_KIND_FAULT;
      state_nxt.prec  = evx_pkg::EVX_PREC_NO;
      state_nxt.cls   = evx_pkg::EVX_CLS_BENIGN;
      state_nxt.valid = 1'b1;
    end else if (alignment_check_exc_in) begin
      state_nxt.vec      = `EVX_VEC_AC;
      state_nxt.kind     = evx_pkg::EVX_KIND_FAULT;
      state_nxt.prec     = evx_pkg::EVX_PREC_YES;
      state_nxt.cls      = evx_pkg::EVX_CLS_BENIGN;
      state_nxt.err_code = 1'b1;
      state_nxt.valid    = 1'b1;
    end else if (simd_float_exc_in) begin
      state_nxt.vec   = `EVX_VEC_XF;
      state_nxt.kind  = evx_pkg::EVX_KIND_FAULT;
      state_nxt.prec  = evx_pkg::EVX_PREC_YES;
      state_nxt.cls   = evx_pkg::EVX_CLS_BENIGN;
      state_nxt.valid = 1'b1;
    end else if (security_exc_in) begin
      state_nxt.vec      = `EVX_VEC_SX;
      state_nxt.prec     = evx_pkg::EVX_PREC_YES;
      state_nxt.cls      = evx_pkg::EVX_CLS_CONTRIB;
      state_nxt.err_code = 1'b1;
      state_nxt.valid    = 1'b1;
    end else if (breakpoint_exc_in) begin
      state_nxt.vec   = `EVX_VEC_BP;
      state_nxt.kind  = evx_pkg::EVX_KIND_TRAP;
      state_nxt.prec  = evx_pkg::EVX_PREC_YES;
      state_nxt.cls   = evx_pkg::EVX_CLS_BENIGN;
      state_nxt.valid = 1'b1;
    end else if (overflow_exc_in) begin
      state_nxt.vec   = `EVX_VEC_OF;
      state_nxt.kind  = evx_pkg::EVX_KIND_TRAP;
      state_nxt.prec  = evx_pkg::EVX_PREC_YES;
      state_nxt.cls   = evx_pkg::EVX_CLS_BENIGN;
      state_nxt.valid = 1'b1;
    end else if (software_interrupt_instr_in) begin
      state_nxt.vec   = software_vector_in;
      state_nxt.cls   = evx_pkg::EVX_CLS_BENIGN;
      state_nxt.ip    = next_ip_in;
      state_nxt.valid = 1'b1;
    end else if (nmi_in) begin
      state_nxt.vec   = `EVX_VEC_NMI;
      state_nxt.ip    = next_ip_in;
      state_nxt.valid = 1'b1;
    end else if (take_irq) begin
      // No type or precision for external requests
      state_nxt.vec   = external_vector_in;
      state_nxt.cls   = evx_pkg::EVX_CLS_BENIGN;
      state_nxt.ip    = next_ip_in;
      state_nxt.ack   = 1'b1;
      state_nxt.valid = 1'b1;
    end
    // An enabled maskable request that loses to a taken event is flagged pending
    if (take_irq && !state_nxt.ack) begin
      state_nxt.pend = 1'b1;
    end
    // Traps resume after the instruction, faults restart it
    if (state_nxt.kind == evx_pkg::EVX_KIND_TRAP) begin
      state_nxt.ip = next_ip_in;
    end
    state_nxt.discard = (state_nxt.kind == evx_pkg::EVX_KIND_FAULT);
    if (state_nxt.valid) begin
      state_nxt.st = evx_pkg::EVX_ST_SHOW;
    end
    case (state_r.st)
      evx_pkg::EVX_ST_IDLE: ;
      evx_pkg::EVX_ST_SHOW: ;
      default: state_nxt.st = evx_pkg::EVX_ST_IDLE;
    endcase
    // Vectors 9, 15, 20-29, 31 have no source wired above
    // Fixed 8-bit code per exception source selects the handler; software and external requests supply their own
  end

  // Single state register, cleared synchronously
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign event_valid_out    = state_r.valid;
  assign event_vector_out   = state_r.vec;
  assign event_kind_out     = state_r.kind;
  assign event_prec_out     = state_r.prec;
  assign event_class_out    = state_r.cls;
  assign event_err_code_out = state_r.err_code;
  assign event_discard_out  = state_r.discard;
  assign saved_ip_out       = state_r.ip;
  assign irq_ack_out        = state_r.ack;
  assign irq_pending_out    = state_r.pend;
endmodule // evx_vector_map
`default_nettype wire

// *** evx_vector_map_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module evx_vector_map_props (
  input wire logic        clk_sys_in,
  input wire logic        rst_in,
  input wire logic        div_req_in,
  input wire logic        div_signed_in,
  input wire logic [15:0] div_dividend_in,
  input wire logic [7:0]  div_divisor_in,
  input wire logic        double_fault_exc_in,
  input wire logic        machine_check_exc_in,
  input wire logic        software_interrupt_instr_in,
  input wire logic        maskable_external_irq_in,
  input wire logic        interrupt_enable_flag_in,
  input wire logic [63:0] cur_ip_in,
  input wire logic [63:0] next_ip_in,
  input wire logic        event_valid_out,
  input wire logic [7:0]  event_vector_out,
  input wire logic [1:0]  event_kind_out,
  input wire logic [1:0]  event_prec_out,
  input wire logic [1:0]  event_class_out,
  input wire logic        event_err_code_out,
  input wire logic        event_discard_out,
  input wire logic [63:0] saved_ip_out,
  input wire logic        irq_ack_out,
  input wire logic        irq_pending_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  logic div_top;
  // Divide only wins when neither abort outranks it
  assign div_top = div_req_in && !double_fault_exc_in && !machine_check_exc_in;
  zero_div_vec_a: assert property (div_top && div_divisor_in == 8'h00 |=>
    event_valid_out && event_vector_out == 8'h00 && event_kind_out == 2'h1
    && event_class_out == 2'h2) else $error("zero divisor not reported");
  div_no_code_a: assert property (div_top && div_divisor_in == 8'h00 |=>
    !event_err_code_out && saved_ip_out == $past(cur_ip_in)) else $error("divide save wrong");
  quot_ovf_a: assert property (div_top && !div_signed_in &&
    div_dividend_in[15:8] >= div_divisor_in |=> event_valid_out && event_vector_out == 8'h00)
    else $error("quotient overflow not reported");
  dbl_abort_a: assert property (double_fault_exc_in |=> event_valid_out &&
    event_vector_out == 8'h08 && event_kind_out == 2'h3 && event_prec_out == 2'h2)
    else $error("double fault attributes wrong");
  irq_held_a: assert property (maskable_external_irq_in && !interrupt_enable_flag_in
    |=> !irq_ack_out && irq_pending_out) else $error("masked request taken or lost");
  irq_benign_a: assert property (irq_ack_out |-> event_valid_out &&
    event_kind_out == 2'h0 && event_prec_out == 2'h0 && event_class_out == 2'h1)
    else $error("external interrupt attributes wrong");
  idle_zero_a: assert property (!event_valid_out |-> event_vector_out == 8'h00 &&
    event_kind_out == 2'h0 && event_prec_out == 2'h0 && event_class_out == 2'h0)
    else $error("fields not cleared without strobe");
  resv_vec_a: assert property (event_valid_out &&
    event_vector_out inside {8'h09, 8'h0f, [8'h14:8'h1d], 8'h1f}
    |-> $past(software_interrupt_instr_in) || irq_ack_out) else $error("reserved vector raised");
  // Faults restart the instruction, traps resume after it
  fault_discard_a: assert property (event_valid_out && event_kind_out == 2'h1 |->
    event_discard_out && saved_ip_out == $past(cur_ip_in)) else $error("fault restart wrong");
  trap_next_a: assert property (event_valid_out && event_kind_out == 2'h2 |->
    !event_discard_out && saved_ip_out == $past(next_ip_in)) else $error("trap resume wrong");
  cover property (irq_ack_out);
  cover property (irq_pending_out);
  cover property (event_valid_out && event_vector_out == 8'h00);
endmodule // evx_vector_map_props
bind evx_vector_map evx_vector_map_props i_props (.clk_sys_in, .rst_in, .div_req_in,
  .div_signed_in, .div_dividend_in, .div_divisor_in, .double_fault_exc_in,
  .machine_check_exc_in, .software_interrupt_instr_in, .maskable_external_irq_in,
  .interrupt_enable_flag_in, .cur_ip_in, .next_ip_in, .event_valid_out, .event_vector_out,
  .event_kind_out, .event_prec_out, .event_class_out, .event_err_code_out,
  .event_discard_out, .saved_ip_out, .irq_ack_out, .irq_pending_out);
`default_nettype wire

// *** test_exception_vector_assignment.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_exception_vector_assignment;
  logic        clk_sys_in, rst_in, div_signed_in, debug_is_trap_in, raise;
  logic        interrupt_enable_flag_in, maskable_external_irq_in, event_valid_out;
  logic        event_err_code_out, event_discard_out, irq_ack_out, irq_pending_out;
  logic [1:0]  event_kind_out, event_prec_out, event_class_out;
  logic [7:0]  div_divisor_in, software_vector_in, external_vector_in;
  logic [7:0]  event_vector_out, raise_vec;
  logic [15:0] div_dividend_in;
  logic [19:0] src;
  logic [63:0] cur_ip_in, next_ip_in, saved_ip_out;
  logic [73:0] p;
  logic [24:0] div_corner [0:5] = '{25'h000_ff01, 25'h001_0001, 25'h1ff_8001,
    25'h100_8001, 25'h180_00ff, 25'h100_80ff};
  logic [7:0]  vec_tab [0:19] = '{8'h08, 8'h12, 8'h00, 8'h01, 8'h05, 8'h06, 8'h07, 8'h0a,
    8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h10, 8'h11, 8'h13, 8'h1e, 8'h03, 8'h04, 8'h00, 8'h02};
  int          fail_count = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  // Sources in priority order, highest first, on bits of src
  evx_vector_map i_dut (
    .double_fault_exc_in(src[0]), .machine_check_exc_in(src[1]), .div_req_in(src[2]),
    .debug_exc_in(src[3]), .bound_range_exc_in(src[4]), .invalid_opcode_exc_in(src[5]),
    .device_unavailable_exc_in(src[6]), .invalid_task_segment_exc_in(src[7]),
    .segment_absent_exc_in(src[8]), .stack_exc_in(src[9]),
    .general_protection_exc_in(src[10]), .page_fault_exc_in(src[11]),
    .float_pending_exc_in(src[12]), .alignment_check_exc_in(src[13]),
    .simd_float_exc_in(src[14]), .security_exc_in(src[15]), .breakpoint_exc_in(src[16]),
    .overflow_exc_in(src[17]), .software_interrupt_instr_in(src[18]), .nmi_in(src[19]), .*);
  evx_irq_source i_src (.clk_sys_in, .rst_in, .raise_in(raise), .vector_in(raise_vec),
    .irq_ack_in(irq_ack_out), .irq_out(maskable_external_irq_in),
    .vector_out(external_vector_in));

  // 20 MHz core clock
  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end

  // Hang guard, far above the 635 cycles needed
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("Checked %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // Signed range is -128..127, unsigned quotient must fit 8 bits
  function automatic logic div_bad();
    int q;
    if (div_divisor_in == 8'h00) return 1'b1;
    if (!div_signed_in) return (div_dividend_in / div_divisor_in) > 255;
    q = $signed(div_dividend_in) / $signed(div_divisor_in);
    return q < -128 || q > 127;
  endfunction

  // {check ip, valid, vector, ip}; traps and interrupts resume after the instruction
  function automatic logic [73:0] predict();
    for (int i = 0; i < 20; i++) begin
      if (src[i] && (i != 2 || div_bad())) begin
        if (i == 18) return {2'b11, software_vector_in, next_ip_in};
        return {i != 15, 1'b1, vec_tab[i],
          (i > 15 || (i == 3 && debug_is_trap_in)) ? next_ip_in : cur_ip_in};
      end
    end
    if (maskable_external_irq_in && interrupt_enable_flag_in)
      return {2'b11, external_vector_in, next_ip_in};
    return {2'b10, 8'h00, cur_ip_in};
  endfunction

  // One sampled cycle: predict, let the edge land, compare
  task automatic step();
    p = predict();
    @(posedge clk_sys_in);
    #1;
    cmp(event_valid_out, p[72]);
    if (p[72]) cmp(event_vector_out, p[71:64]);
    if (p[73]) cmp(saved_ip_out, p[63:0]);
  endtask

  task automatic shake();
    cur_ip_in = {$urandom, $urandom};
    next_ip_in = {$urandom, $urandom};
    debug_is_trap_in = 1'($urandom);
    software_vector_in = 8'($urandom);
    div_signed_in = 1'($urandom);
    div_dividend_in = 16'($urandom);
    div_divisor_in = ($urandom_range(3, 0) == 0) ? 8'h00 : 8'($urandom);
  endtask

  // Main sequence
  initial begin
    {src, raise, raise_vec, div_signed_in, div_dividend_in, div_divisor_in} = '0;
    {interrupt_enable_flag_in, debug_is_trap_in, software_vector_in} = '0;
    {cur_ip_in, next_ip_in} = '0;
    rst_in = 1'b1;
    void'($urandom(20));
    repeat (6) @(posedge clk_sys_in);
    #1;
    rst_in = 1'b0;
    step();
    for (int i = 0; i < 20; i++) begin
      shake();
      src = 20'h0_0001 << i;
      step();
    end
    for (int v = 0; v < 256; v++) begin
      shake();
      src = 20'h4_0000;
      software_vector_in = v[7:0];
      step();
    end
    for (int k = 0; k < 46; k++) begin
      shake();
      src = 20'h0_0004;
      if (k < 6) {div_signed_in, div_dividend_in, div_divisor_in} = div_corner[k];
      step();
    end
    src = '0;
    raise = 1'b1;
    raise_vec = 8'hc5;
    step();
    raise = 1'b0;
    repeat (3) begin
      step();
      cmp(irq_pending_out, 1'b1);
    end
    interrupt_enable_flag_in = 1'b1;
    step();
    cmp(irq_ack_out, 1'b1);
    cmp(event_class_out, 2'h1);
    step();
    cmp(irq_pending_out, 1'b0);
    for (int k = 0; k < 300; k++) begin
      shake();
      src = (20'h0_0001 << $urandom_range(19, 0)) | (20'h0_0001 << $urandom_range(19, 0));
      interrupt_enable_flag_in = 1'($urandom);
      raise = 1'($urandom);
      raise_vec = 8'($urandom);
      step();
    end
    end_of_test();
  end
endmodule // test_exception_vector_assignment
`default_nettype wire
